// ---- rtl/fstu_pkg.sv ----
// fstu_pkg: constants, types and operand screening of the stack unit
// assumes one decoded command per cycle from the decoder, flags valid
package fstu_pkg;
  localparam logic [14:0] EXP_MAX    = 15'h7fff;
  localparam logic [14:0] EXP_ONE    = 15'h0001;
  localparam logic [15:0] BIAS_X     = 16'h3fff;
  localparam logic [15:0] BIAS_S     = 16'h007f;
  localparam logic [15:0] BIAS_D     = 16'h03ff;
  localparam logic [15:0] EXP_INT    = 16'h403e;
  localparam logic [63:0] BCD_LIMIT  = 64'h0de0_b6b3_a764_0000;
  localparam logic [63:0] INT_INDEF  = 64'h8000_0000_0000_0000;
  localparam logic [79:0] REAL_INDEF = 80'hffff_c000_0000_0000_0000;
  localparam logic [79:0] BCD_INDEF  = 80'hffff_0000_0000_0000_0000;
  localparam logic [4:0]  ESC_CODE   = 5'h1b;
  localparam logic [3:0]  ADDR_STATUS = 4'h0;
  localparam logic [3:0]  ADDR_ENABLE = 4'h1;
  localparam logic [3:0]  ADDR_CLEAR  = 4'h2;
  localparam logic [3:0]  ADDR_STACK  = 4'h3;
  localparam int          EV_INVALID  = 0;
  localparam int          EV_DENORMAL = 1;
  localparam int          EV_ESCAPE   = 2;
  localparam logic [2:0]  EV_RST      = 3'h0;
  localparam logic [2:0]  TOP_RST     = 3'h0;
  localparam logic [7:0]  TAG_RST     = 8'h00;

  typedef struct packed {
    logic        sign;
    logic [14:0] exp;
    logic        intb;
    logic [62:0] frac;
  } fstu_ext_t;

  typedef enum logic [3:0] {
    nop_op, load_real_op, load_integer_op, load_packed_decimal_op,
    store_real_op, store_integer_op, store_real_pop_op,
    store_integer_pop_op, store_packed_decimal_pop_op,
    exchange_op, conditional_move_op
  } fstu_op_t;

  typedef enum logic [2:0] {
    cc_b, cc_nb, cc_e, cc_ne, cc_be, cc_nbe, cc_u, cc_nu
  } fstu_cond_t;

  typedef enum logic [2:0] {
    fmt_single, fmt_double, fmt_ext, fmt_int, fmt_bcd
  } fstu_fmt_t;

  typedef enum logic {src_mem, src_stack} fstu_src_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  escape;
    fstu_op_t    op;
    fstu_src_t   src;
    fstu_fmt_t   fmt;
    fstu_cond_t  cond;
    logic [2:0]  sel;
    logic [79:0] mem_data;
  } fstu_cmd_t;

  typedef struct packed {
    logic carry_flag;
    logic zero_flag;
    logic parity_flag;
  } fstu_flags_t;

  typedef struct packed {
    logic        valid;
    fstu_fmt_t   fmt;
    logic [79:0] data;
  } fstu_wr_t;

  function automatic logic is_unsup(fstu_ext_t x);
    return !x.intb && x.exp != 15'h0000;
  endfunction : is_unsup

  function automatic logic is_pden(fstu_ext_t x);
    return x.intb && x.exp == 15'h0000;
  endfunction : is_pden
endpackage : fstu_pkg

// ---- rtl/fstu_top.sv ----
// fstu_top: register stack, load/store conversion and operand screening
// assumes the load path supplies memory operands already fetched and
// integers sign-extended to 64 bits
`timescale 1ns/100ps
module fstu_top (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire fstu_pkg::fstu_cmd_t   cmd,
  input  wire fstu_pkg::fstu_flags_t flags,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               rdata_reg,
  output fstu_pkg::fstu_wr_t         mem_wr_reg,
  output logic                      done_reg,
  output logic                      irq_reg
);
  import fstu_pkg::*;

  // ****************************************
  // conversion functions
  // ****************************************
  function automatic fstu_ext_t norm_x(logic s, logic [63:0] m,
                                       logic [15:0] e);
    fstu_ext_t   r;
    logic [63:0] mm;
    logic [15:0] ee;
    r  = '0;
    mm = m;
    ee = e;
    r.sign = s;
    if (m != 64'h0) begin
      for (int i = 0; i < 63; i++) begin
        if (!mm[63] && ee > 16'h0001) begin
          mm = mm << 1;
          ee = ee - 16'h0001;
        end
      end
      r.exp  = mm[63] ? ee[14:0] : 15'h0000;
      r.intb = mm[63];
      r.frac = mm[62:0];
    end
    return r;
  endfunction : norm_x
  function automatic fstu_ext_t cvt_load(logic [79:0] d, fstu_fmt_t f);
    fstu_ext_t   r;
    logic [63:0] m;
    r = d;
    m = 64'h0;
    case (f)
      fmt_single: begin
        if (d[30:23] == 8'hff)
          r = {d[31], EXP_MAX, 1'b1, d[22:0], 40'h0};
        else if (d[30:23] == 8'h00)
          r = norm_x(d[31], {1'b0, d[22:0], 40'h0}, BIAS_X - BIAS_S + 16'h1);
        else
          r = norm_x(d[31], {1'b1, d[22:0], 40'h0},
                     {8'h0, d[30:23]} + BIAS_X - BIAS_S);
      end
      fmt_double: begin
        if (d[62:52] == 11'h7ff)
          r = {d[63], EXP_MAX, 1'b1, d[51:0], 11'h0};
        else if (d[62:52] == 11'h000)
          r = norm_x(d[63], {1'b0, d[51:0], 11'h0}, BIAS_X - BIAS_D + 16'h1);
        else
          r = norm_x(d[63], {1'b1, d[51:0], 11'h0},
                     {5'h0, d[62:52]} + BIAS_X - BIAS_D);
      end
      fmt_int: begin
        m = d[63] ? 64'h0 - d[63:0] : d[63:0];
        r = norm_x(d[63], m, EXP_INT);
      end
      fmt_bcd: begin
        for (int i = 17; i >= 0; i--) begin
          m = m * 64'h000a + {60'h0, d[4*i +: 4]};
        end
        r = norm_x(d[79], m, EXP_INT);
      end
      default: r = d;
    endcase
    return r;
  endfunction : cvt_load
  // truncates toward zero; returns {invalid, image}
  function automatic logic [80:0] cvt_store(fstu_ext_t x, fstu_fmt_t f);
    logic [80:0] r;
    logic [17:0] ue;
    logic [63:0] mag;
    logic [71:0] bcd;
    r   = {1'b0, x};
    ue  = {3'h0, x.exp} - {2'h0, BIAS_X};
    mag = 64'h0;
    bcd = 72'h0;
    case (f)
      fmt_single: begin
        ue = ue + {2'h0, BIAS_S};
        if (x.exp == EXP_MAX || (!ue[17] && ue > 18'h000fe))
          r = {49'h0, x.sign, 8'hff, x.exp == EXP_MAX ? x.frac[62:40] : 23'h0};
        else if (ue[17] || ue == 18'h0)
          r = {49'h0, x.sign, 31'h0};
        else
          r = {49'h0, x.sign, ue[7:0], x.frac[62:40]};
      end
      fmt_double: begin
        ue = ue + {2'h0, BIAS_D};
        if (x.exp == EXP_MAX || (!ue[17] && ue > 18'h007fe))
          r = {17'h0, x.sign, 11'h7ff, x.exp == EXP_MAX ? x.frac[62:11] : 52'h0};
        else if (ue[17] || ue == 18'h0)
          r = {17'h0, x.sign, 63'h0};
        else
          r = {17'h0, x.sign, ue[10:0], x.frac[62:11]};
      end
      fmt_int, fmt_bcd: begin
        if (!ue[17] && ue > 18'h0003e)
          r = {1'b1, 16'h0, INT_INDEF};
        else begin
          if (!ue[17])
            mag = {x.intb, x.frac} >> (6'h3f - ue[5:0]);
          r = {17'h0, x.sign ? 64'h0 - mag : mag};
          if (f == fmt_bcd) begin
            for (int i = 63; i >= 0; i--) begin
              for (int j = 0; j < 18; j++) begin
                if (bcd[4*j +: 4] > 4'h4)
                  bcd[4*j +: 4] = bcd[4*j +: 4] + 4'h3;
              end
              bcd = {bcd[70:0], mag[i]};
            end
            r = {1'b0, x.sign, 7'h0, bcd};
          end
        end
        if (f == fmt_bcd && (r[80] || mag >= BCD_LIMIT))
          r = {1'b1, BCD_INDEF};
      end
      default: r = {1'b0, x};
    endcase
    return r;
  endfunction : cvt_store
  function automatic logic cond_ok(fstu_cond_t c, fstu_flags_t fl);
    case (c)
      cc_b:    return fl.carry_flag;
      cc_nb:   return !fl.carry_flag;
      cc_e:    return fl.zero_flag;
      cc_ne:   return !fl.zero_flag;
      cc_be:   return fl.carry_flag | fl.zero_flag;
      cc_nbe:  return !(fl.carry_flag | fl.zero_flag);
      cc_u:    return fl.parity_flag;
      default: return !fl.parity_flag;
    endcase
  endfunction : cond_ok
  // ****************************************
  // state
  // ****************************************
  fstu_ext_t   stack_reg [8];
  logic [7:0]  tag_reg;
  logic [2:0]  top_reg;
  logic [2:0]  status_reg;
  logic [2:0]  enable_reg;
  fstu_ext_t   top_val, sel_val, opnd, fixed;
  logic [2:0]  sel_idx, push_idx, wa_idx, ev;
  fstu_ext_t   wa_val, wb_val;
  logic        go, wa_en, wb_en, push, pop, chk, st_en;
  logic        bad, den, esc_bad;
  fstu_fmt_t   st_fmt;
  logic [80:0] st_img;

  // ****************************************
  // decode
  // ****************************************
  always_comb begin
    go       = cmd.valid && cmd.escape == ESC_CODE;
    esc_bad  = cmd.valid && cmd.escape != ESC_CODE;
    sel_idx  = top_reg + cmd.sel;
    push_idx = top_reg - 3'h1;
    top_val  = stack_reg[top_reg];
    sel_val  = stack_reg[sel_idx];
    if (cmd.op == load_real_op && cmd.src == src_stack)
      opnd = sel_val;
    else if (cmd.op == load_real_op || cmd.op == load_integer_op ||
             cmd.op == load_packed_decimal_op)
      opnd = cvt_load(cmd.mem_data, cmd.op == load_integer_op ? fmt_int :
                      cmd.op == load_packed_decimal_op ? fmt_bcd : cmd.fmt);
    else if (cmd.op == conditional_move_op)
      opnd = sel_val;
    else
      opnd = top_val;
    bad   = is_unsup(opnd);
    den   = is_pden(opnd);
    fixed = opnd;
    if (den)
      fixed.exp = EXP_ONE;
    if (bad)
      fixed = REAL_INDEF;
    wa_en  = 1'b0;
    wa_idx = top_reg;
    wa_val = fixed;
    wb_en  = 1'b0;
    wb_val = top_val;
    push   = 1'b0;
    pop    = 1'b0;
    chk    = 1'b0;
    st_en  = 1'b0;
    st_fmt = cmd.fmt;
    case (cmd.op)
      load_real_op, load_integer_op, load_packed_decimal_op: begin
        wa_en  = 1'b1;
        wa_idx = push_idx;
        push   = 1'b1;
        chk    = 1'b1;
      end
      store_real_op: begin
        st_en = 1'b1;
        chk   = 1'b1;
      end
      store_integer_op: begin
        st_en  = 1'b1;
        st_fmt = fmt_int;
        chk    = 1'b1;
      end
      store_real_pop_op: begin
        wa_en  = cmd.src == src_stack;
        wa_idx = sel_idx;
        st_en  = cmd.src == src_mem;
        pop    = 1'b1;
        chk    = 1'b1;
      end
      store_integer_pop_op, store_packed_decimal_pop_op: begin
        st_en  = 1'b1;
        st_fmt = cmd.op == store_integer_pop_op ? fmt_int : fmt_bcd;
        pop    = 1'b1;
        chk    = 1'b1;
      end
      exchange_op: begin
        wa_en  = 1'b1;
        wa_val = sel_val;
        wb_en  = 1'b1;
      end
      conditional_move_op: begin
        wa_en = cond_ok(cmd.cond, flags);
        chk   = wa_en;
      end
      default: ;
    endcase
    st_img = cvt_store(fixed, st_fmt);
    ev = '0;
    ev[EV_INVALID]  = go && chk && (bad || (st_en && st_img[80]));
    ev[EV_DENORMAL] = go && chk && den;
    ev[EV_ESCAPE]   = esc_bad;
  end

  // ****************************************
  // register stack
  // ****************************************
  // exchange writes two slots in one edge; others write at most one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stack_reg <= '{default: '0};
    end else if (go) begin
      if (wa_en)
        stack_reg[wa_idx] <= wa_val;
      if (wb_en)
        stack_reg[sel_idx] <= wb_val;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      top_reg <= TOP_RST;
    else if (go && push)
      top_reg <= push_idx;
    else if (go && pop)
      top_reg <= top_reg + 3'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      tag_reg <= TAG_RST;
    else if (go && push)
      tag_reg[push_idx] <= 1'b1;
    else if (go && pop)
      tag_reg[top_reg] <= 1'b0;
  end

  // ****************************************
  // memory store port
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_wr_reg <= '0;
      done_reg   <= 1'b0;
    end else begin
      mem_wr_reg.valid <= go && st_en;
      mem_wr_reg.fmt   <= st_fmt;
      mem_wr_reg.data  <= st_img[79:0];
      done_reg         <= go;
    end
  end

  // ****************************************
  // registers and interrupt
  // ****************************************
  // a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst)
      status_reg <= EV_RST;
    else if (reg_wr && reg_addr == ADDR_CLEAR)
      status_reg <= (status_reg & ~reg_wdata[2:0]) | ev;
    else
      status_reg <= status_reg | ev;
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      enable_reg <= EV_RST;
    else if (reg_wr && reg_addr == ADDR_ENABLE)
      enable_reg <= reg_wdata[2:0];
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(status_reg & enable_reg);
  end

  // unmapped and write-only addresses read zero
  always_ff @(posedge ref_clk) begin
    if (rst || !reg_rd)
      rdata_reg <= '0;
    else
      case (reg_addr)
        ADDR_STATUS: rdata_reg <= {29'h0, status_reg};
        ADDR_ENABLE: rdata_reg <= {29'h0, enable_reg};
        ADDR_STACK:  rdata_reg <= {21'h0, tag_reg, top_reg};
        default:     rdata_reg <= '0;
      endcase
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_push;
    go && push;
  endsequence
  sequence s_pop;
    go && pop;
  endsequence
  AST_PUSH: assert property (
    s_push |=> top_reg == $past(top_reg) - 3'h1 && tag_reg[top_reg])
    else $error("push did not move top down and tag slot");
  AST_POP: assert property (
    s_pop |=> top_reg == $past(top_reg) + 3'h1 && !tag_reg[$past(top_reg)])
    else $error("pop did not free top slot");
  AST_INVALID: assert property (
    go && chk && bad |=> status_reg[EV_INVALID])
    else $error("unsupported operand not flagged");
  AST_DENORMAL: assert property (
    go && chk && den |=> status_reg[EV_DENORMAL])
    else $error("pseudo-denormal not flagged");
  AST_NO_PDEN: assert property (
    go && wa_en && cmd.op != exchange_op |=> !is_pden(stack_reg[$past(wa_idx)]))
    else $error("pseudo-denormal result written");
  AST_STORE_KEEP: assert property (
    go && cmd.op == store_real_op |=> $stable(top_reg) && mem_wr_reg.valid)
    else $error("store changed stack or wrote nothing");
  AST_CMOV_HOLD: assert property (
    go && cmd.op == conditional_move_op && !cond_ok(cmd.cond, flags)
    |=> $stable(stack_reg[top_reg]))
    else $error("false condition moved a value");
  AST_ESCAPE: assert property (
    esc_bad |=> $stable(top_reg) && !done_reg && status_reg[EV_ESCAPE])
    else $error("non-escape command acted");
  AST_IRQ: assert property (irq_reg == $past(|(status_reg & enable_reg)))
    else $error("interrupt does not follow enabled events");
endmodule : fstu_top

// ---- bench/fstu_partner.sv ----
// fstu_partner: decoder and load/store path model facing the stack unit
// assumes one clock; the bench hands it one command at a time
`timescale 1ns/100ps
module fstu_partner (
  input  wire logic                 ref_clk,
  output fstu_pkg::fstu_cmd_t        cmd,
  output fstu_pkg::fstu_flags_t      flags,
  input  wire fstu_pkg::fstu_wr_t    mem_wr,
  input  wire logic                 done
);
  import fstu_pkg::*;

  initial begin
    cmd = '0;
    flags = '0;
  end

  // ****************************************
  // command hand-over
  // ****************************************
  task automatic issue(input fstu_cmd_t c, input fstu_flags_t f,
                       output logic dn, output fstu_wr_t wr);
    @(posedge ref_clk);
    cmd <= c;
    flags <= f;
    @(posedge ref_clk);
    cmd.valid <= 1'b0;
    // released operand lines do not keep the old value
    cmd.mem_data <= ~c.mem_data;
    flags <= ~f;
    #1;
    dn = done;
    wr = mem_wr;
  endtask : issue
endmodule : fstu_partner

// ---- bench/fstu_top_tb.sv ----
// fstu_top_tb: self-checking bench for the stack transfer unit
// assumes fstu_partner drives commands and flags, bench drives registers
`timescale 1ns/100ps
module fstu_top_tb;
  import fstu_pkg::*;
  localparam logic [79:0] VA = 80'h3fff_8000_0000_0000_0000;
  localparam logic [79:0] VB = 80'h3fff_c000_0000_0000_0000;
  localparam logic [79:0] VC = 80'h4000_8000_0000_0000_0000;
  logic        ref_clk;
  logic        rst;
  fstu_cmd_t   cmd;
  fstu_flags_t flags;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] rdata_reg;
  fstu_wr_t    mem_wr_reg;
  logic        done_reg;
  logic        irq_reg;
  logic        dn;
  fstu_wr_t    wr;
  int          n_mismatch;
  int          check_count;
  int          cycles;

  fstu_top u_fstu_top (
    .ref_clk(ref_clk), .rst(rst), .cmd(cmd), .flags(flags),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .rdata_reg(rdata_reg), .mem_wr_reg(mem_wr_reg),
    .done_reg(done_reg), .irq_reg(irq_reg)
  );

  fstu_partner u_fstu_partner (
    .ref_clk(ref_clk), .cmd(cmd), .flags(flags),
    .mem_wr(mem_wr_reg), .done(done_reg)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // a hang is counted as a mismatch
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      n_mismatch = n_mismatch + 1;
      conclude();
    end
  end

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(rdata_reg, exp);
  endtask : reg_read

  task automatic run(input fstu_op_t op, input fstu_src_t src, input fstu_fmt_t fmt,
                     input logic [2:0] sel, input logic [79:0] d,
                     input fstu_cond_t cc = cc_b, input fstu_flags_t f = '0,
                     input logic [4:0] escape_format = ESC_CODE);
    fstu_cmd_t c;
    c = '{valid: 1'b1, escape: escape_format, op: op, src: src, fmt: fmt, cond: cc,
          sel: sel, mem_data: d};
    u_fstu_partner.issue(c, f, dn, wr);
  endtask : run

  task automatic push(input logic [79:0] d);
    run(load_real_op, src_mem, fmt_ext, 3'h0, d);
    chk(dn, 1'b1);
  endtask : push

  task automatic pop_chk(input logic [79:0] exp);
    run(store_real_pop_op, src_mem, fmt_ext, 3'h0, 80'h0);
    chk(wr.valid, 1'b1);
    chk(wr.data, exp);
    chk(wr.fmt, fmt_ext);
  endtask : pop_chk

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    reg_read(ADDR_STATUS, 32'h0);
    reg_read(ADDR_ENABLE, 32'h0);
    reg_read(ADDR_STACK, 32'h0);
    reg_read(ADDR_CLEAR, 32'h0);
    reg_write(ADDR_STATUS, 32'h7);
    reg_write(4'hf, 32'hffff_ffff);
    reg_read(ADDR_STATUS, 32'h0);
    reg_read(4'hf, 32'h0);
  endtask : t_regs

  task automatic t_push_pop();
    push(VB);
    reg_read(ADDR_STACK, 32'h407);
    run(store_real_op, src_mem, fmt_single, 3'h0, 80'h0);
    chk(wr.data[31:0], 32'h3fc0_0000);
    run(store_real_op, src_mem, fmt_double, 3'h0, 80'h0);
    chk(wr.data[63:0], 64'h3ff8_0000_0000_0000);
    reg_read(ADDR_STACK, 32'h407);
    pop_chk(VB);
    reg_read(ADDR_STACK, 32'h0);
    run(load_real_op, src_mem, fmt_single, 3'h0, 80'h3fc0_0000);
    pop_chk(VB);
    run(load_real_op, src_mem, fmt_double, 3'h0, 80'h3ff8_0000_0000_0000);
    pop_chk(VB);
    push(80'hbf00_8000_0000_0000_0000);
    run(store_real_op, src_mem, fmt_single, 3'h0, 80'h0);
    chk(wr.data[31:0], 32'h8000_0000);
    pop_chk(80'hbf00_8000_0000_0000_0000);
  endtask : t_push_pop

  task automatic t_int_bcd();
    run(load_integer_op, src_mem, fmt_int, 3'h0, 80'hffff_ffff_ffff_fffe);
    run(store_real_op, src_mem, fmt_ext, 3'h0, 80'h0);
    chk(wr.data, 80'hc000_8000_0000_0000_0000);
    run(store_integer_pop_op, src_mem, fmt_int, 3'h0, 80'h0);
    chk(wr.data[63:0], 64'hffff_ffff_ffff_fffe);
    chk(wr.fmt, fmt_int);
    run(load_packed_decimal_op, src_mem, fmt_bcd, 3'h0, 80'h123);
    run(store_real_op, src_mem, fmt_ext, 3'h0, 80'h0);
    chk(wr.data, 80'h4005_f600_0000_0000_0000);
    run(store_packed_decimal_pop_op, src_mem, fmt_bcd, 3'h0, 80'h0);
    chk(wr.data, 80'h123);
    chk(wr.fmt, fmt_bcd);
    reg_read(ADDR_STACK, 32'h0);
  endtask : t_int_bcd

  task automatic t_moves();
    push(VA);
    push(VB);
    run(exchange_op, src_stack, fmt_ext, 3'h1, 80'h0);
    pop_chk(VA);
    pop_chk(VB);
    push(VA);
    push(VB);
    run(load_real_op, src_stack, fmt_ext, 3'h1, 80'h0);
    pop_chk(VA);
    pop_chk(VB);
    pop_chk(VA);
    push(VA);
    push(VB);
    push(VC);
    run(store_real_pop_op, src_stack, fmt_ext, 3'h2, 80'h0);
    chk(wr.valid, 1'b0);
    pop_chk(VB);
    pop_chk(VC);
    reg_read(ADDR_STACK, 32'h0);
  endtask : t_moves

  task automatic t_cmov();
    logic [2:0] cc;
    logic [2:0] f;
    logic       hit;
    for (int i = 0; i < 64; i++) begin
      cc = i[2:0];
      f = i[5:3];
      case (cc[2:1])
        2'h0: hit = f[2];
        2'h1: hit = f[1];
        2'h2: hit = f[2] | f[1];
        default: hit = f[0];
      endcase
      hit = hit ^ cc[0];
      push(VA);
      push(VB);
      run(conditional_move_op, src_stack, fmt_ext, 3'h1, 80'h0, fstu_cond_t'(cc),
          fstu_flags_t'(f));
      pop_chk(hit ? VA : VB);
      pop_chk(VA);
    end
  endtask : t_cmov

  task automatic t_screen();
    logic [79:0] bad [3];
    bad = '{80'h7fff_4000_0000_0000_0000, 80'hffff_0000_0000_0000_0000,
            80'h4000_4000_0000_0000_0000};
    reg_write(ADDR_ENABLE, 32'h1);
    reg_read(ADDR_ENABLE, 32'h1);
    for (int i = 0; i < 3; i++) begin
      push(bad[i]);
      reg_read(ADDR_STATUS, 32'h1);
      chk(irq_reg, 1'b1);
      pop_chk(REAL_INDEF);
      reg_write(ADDR_CLEAR, 32'h1);
      reg_read(ADDR_STATUS, 32'h0);
      chk(irq_reg, 1'b0);
    end
    push(80'h8000_8000_0000_0000_1234);
    reg_read(ADDR_STATUS, 32'h2);
    chk(irq_reg, 1'b0);
    pop_chk(80'h8001_8000_0000_0000_1234);
    reg_write(ADDR_CLEAR, 32'h7);
    push(80'h4040_8000_0000_0000_0000);
    run(store_integer_pop_op, src_mem, fmt_int, 3'h0, 80'h0);
    chk(wr.data[63:0], INT_INDEF);
    reg_read(ADDR_STATUS, 32'h1);
    reg_write(ADDR_CLEAR, 32'h7);
    run(load_real_op, src_mem, fmt_ext, 3'h0, VA, cc_b, 3'h0, 5'h00);
    chk(dn, 1'b0);
    reg_read(ADDR_STACK, 32'h0);
    reg_read(ADDR_STATUS, 32'h4);
  endtask : t_screen

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    cycles = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_push_pop();
    t_int_bcd();
    t_moves();
    t_cmov();
    t_screen();
    conclude();
  end
endmodule : fstu_top_tb
